// File: hdl/prc_pkg.sv
// Constants, types and helpers of the power rail command register bank
package prc_pkg;

  localparam int NREG = 23;
  localparam int CLK_HZ = 40000000;
  localparam int PKT_TIMEOUT_MS = 20;
  localparam int SLEW_TICK_US = 1000;
  localparam int NVM_BUSY_CYC = 64;

  // Slot indices into the register array
  localparam int IX_PAGE = 0;
  localparam int IX_OP = 1;
  localparam int IX_CFG = 2;
  localparam int IX_WP = 3;
  localparam int IX_VCMD = 6;
  localparam int IX_VMAX = 7;
  localparam int IX_MHI = 8;
  localparam int IX_MLO = 9;
  localparam int IX_SLEW = 10;
  localparam int IX_VON = 12;
  localparam int IX_VOFF = 13;
  localparam int IX_OVA = 16;
  localparam int IX_UVA = 20;
  localparam int IX_OCA = 22;

  localparam logic [0:NREG-1][7:0] REG_CODE = {
    8'h00, 8'h01, 8'h02, 8'h10, 8'h19, 8'h20, 8'h21, 8'h24,
    8'h25, 8'h26, 8'h27, 8'h33, 8'h35, 8'h36, 8'h38, 8'h40,
    8'h41, 8'h42, 8'h43, 8'h44, 8'h45, 8'h46, 8'h47};
  localparam logic [0:NREG-1][15:0] REG_RESET = {
    16'h0000, 16'h0080, 16'h001E, 16'h0000, 16'h00B0, 16'h0014,
    16'h1000, 16'h5800, 16'h10CD, 16'h0F33, 16'hAA00, 16'hFABC,
    16'hCB40, 16'hCB00, 16'hBB9A, 16'h119A, 16'h00B8, 16'h1133,
    16'h0ECD, 16'h0E66, 16'h00B8, 16'hDBB8, 16'h0000};
  localparam logic [0:NREG-1] REG_WORD = 23'h01FFBA;
  localparam logic [0:NREG-1] REG_RO = 23'h060000;
  localparam logic [0:NREG-1] REG_NV = 23'h39FFFF;

  // Send-byte commands and code ranges
  localparam logic [7:0] CMD_CLEAR = 8'h03;
  localparam logic [7:0] CMD_STORE = 8'h15;
  localparam logic [7:0] CMD_RESTORE = 8'h16;
  localparam logic [7:0] RESERVED_LO = 8'hD0;
  localparam logic [7:0] NO_DATA = 8'hFF;

  // Field positions
  localparam int OP_ON = 7;
  localparam logic [1:0] MARGIN_LOW = 2'h1;
  localparam logic [1:0] MARGIN_HIGH = 2'h2;
  localparam int CFG_USE = 4;
  localparam int CFG_CMD = 3;
  localparam int CFG_PIN = 2;
  localparam int CFG_POL = 1;
  localparam int WP_ALL = 7;
  localparam int WP_OP = 6;
  localparam int WP_CFG = 5;

  typedef enum logic [1:0] {
    KIND_READ = 2'b00,
    KIND_WRITE = 2'b01,
    KIND_SEND = 2'b10
  } prc_kind_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ_HI = 2'b01,
    ST_STORE = 2'b10,
    ST_RESTORE = 2'b11
  } prc_st_t;

  typedef struct packed {
    logic valid;
    prc_kind_t kind;
    logic word;
    logic [7:0] code;
    logic [7:0] dataLo;
    logic [7:0] dataHi;
  } prc_req_t;

  typedef struct packed {
    logic ready;
    logic busy;
    logic rdValid;
    logic rdLast;
    logic [7:0] rdByte;
  } prc_rsp_t;

  typedef struct packed {
    logic ov;
    logic uv;
    logic oc;
    logic commsMemoryFault;
    logic busyFault;
  } prc_fault_t;

  // Short_float_format word to fixed point with 16 fraction bits
  function automatic logic [47:0] prcL11(input logic [15:0] w);
    logic [5:0] sh;
    logic [47:0] v;
    sh = {w[15], w[15:11]} + 6'h10;
    v = w[10] ? 48'h0 : {37'h0, w[10:0]};
    prcL11 = v << sh;
  endfunction

  // Code lookup: hit flag and slot index
  function automatic logic [5:0] prcSlot(input logic [7:0] code);
    prcSlot = 6'h00;
    for (int i = 0; i < NREG; i++)
    begin
      if (REG_CODE[i] == code)
      begin
        prcSlot = {1'b1, 5'(i)};
      end
    end
  endfunction

endpackage

// File: hdl/prc_rail_cmd_bank.sv
// Power rail command register bank with EEPROM shadow and rail control
`timescale 1ns/1ps
module prc_rail_cmd_bank
  import prc_pkg::*;
#(
  parameter int PKT_CYC = PKT_TIMEOUT_MS * (CLK_HZ / 1000),
  parameter int TICK_CYC = SLEW_TICK_US * (CLK_HZ / 1000000)
)
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire prc_req_t req,
  output prc_rsp_t rsp,
  input wire logic pktStart,
  input wire logic pktDone,
  output logic pktAbort,
  input wire logic enablePin,
  input wire logic [15:0] vinMeas,
  input wire logic ovDetect,
  input wire logic uvDetect,
  input wire logic ocDetect,
  output prc_fault_t faults,
  output logic convActive,
  output logic railEnable,
  output logic [15:0] voutNow,
  output logic [0:NREG-1][15:0] regView
);

  typedef struct packed {
    prc_st_t st;
    logic [0:NREG-1][15:0] regs;
    logic [0:NREG-1][15:0] nvm;
    logic [7:0] nvmCnt;
    logic [19:0] pktCnt;
    logic pktRun;
    logic pktAbort;
    logic [15:0] tickCnt;
    logic [15:0] vout;
    logic convOn;
    logic offLatch;
    prc_fault_t faults;
    logic rdValid;
    logic rdLast;
    logic [7:0] rdByte;
    logic [7:0] hiByte;
    logic [1:0] pinSync;
  } prc_state_t;

  prc_state_t cur;
  prc_state_t next_cur;

  logic take;
  logic [5:0] slot;
  logic [4:0] ix;
  logic hit;
  logic reserved;
  logic wpBlock;
  logic pinActive;
  logic railReq;
  logic railOn;
  logic [15:0] sel;
  logic [15:0] target;
  logic [47:0] stepWide;
  logic [15:0] step;
  logic [47:0] vinFix;
  logic tick;

  // Request decode
  assign take = req.valid && (cur.st == ST_IDLE);
  assign slot = prcSlot(req.code);
  assign hit = slot[5];
  assign ix = slot[4:0];
  assign reserved = (req.code >= RESERVED_LO);

  // Guard byte: which writes are still allowed
  always_comb
  begin
    wpBlock = 1'b0;
    if (cur.regs[IX_WP][WP_ALL])
    begin
      wpBlock = (ix != 5'(IX_WP));
    end
    else if (cur.regs[IX_WP][WP_OP])
    begin
      wpBlock = (ix != 5'(IX_WP)) && (ix != 5'(IX_OP));
    end
    else if (cur.regs[IX_WP][WP_CFG])
    begin
      wpBlock = (ix != 5'(IX_WP)) && (ix != 5'(IX_OP)) &&
                (ix != 5'(IX_CFG)) && (ix != 5'(IX_VCMD));
    end
  end

  // Rail on request from pin and/or command
  always_comb
  begin
    pinActive = cur.regs[IX_CFG][CFG_POL] ? cur.pinSync[1]
                                           : ~cur.pinSync[1];
    railReq = 1'b1;
    if (cur.regs[IX_CFG][CFG_USE])
    begin
      railReq = (~cur.regs[IX_CFG][CFG_CMD] |
                 cur.regs[IX_OP][OP_ON]) &
                (~cur.regs[IX_CFG][CFG_PIN] | pinActive);
    end
    railOn = railReq && cur.convOn && !cur.offLatch;
  end

  // Set point choice, clamp and slew step
  always_comb
  begin
    case (cur.regs[IX_OP][5:4])
      MARGIN_HIGH: sel = cur.regs[IX_MHI];
      MARGIN_LOW: sel = cur.regs[IX_MLO];
      default: sel = cur.regs[IX_VCMD];
    endcase
    if (sel > cur.regs[IX_VMAX])
    begin
      sel = cur.regs[IX_VMAX];
    end
    target = railOn ? sel : 16'h0000;
    // Volts per tick to output LSBs of 2^-12 V
    stepWide = prcL11(cur.regs[IX_SLEW]) >> 4;
    step = (|stepWide[47:16]) ? 16'hFFFF : stepWide[15:0];
    if (step == 16'h0000)
    begin
      step = 16'h0001;
    end
    vinFix = prcL11(vinMeas);
    tick = (cur.tickCnt == 16'(TICK_CYC - 1));
  end

  // Next state
  always_comb
  begin
    next_cur = cur;
    next_cur.rdValid = 1'b0;
    next_cur.rdLast = 1'b0;
    next_cur.pinSync = {cur.pinSync[0], enablePin};

    // Fault clear first so that any new event below wins
    if (take && !cur.pktAbort && req.kind == KIND_SEND &&
        req.code == CMD_CLEAR)
    begin
      next_cur.faults = '0;
    end
    if (ovDetect)
    begin
      next_cur.faults.ov = 1'b1;
    end
    if (uvDetect)
    begin
      next_cur.faults.uv = 1'b1;
    end
    if (ocDetect)
    begin
      next_cur.faults.oc = 1'b1;
    end
    if (req.valid && cur.st != ST_IDLE)
    begin
      next_cur.faults.busyFault = 1'b1;
    end

    // Programmed fault actions latch the rail off
    if ((ovDetect && |cur.regs[IX_OVA][7:6]) ||
        (uvDetect && |cur.regs[IX_UVA][7:6]))
    begin
      next_cur.offLatch = 1'b1;
    end
    if (ocDetect && |cur.regs[IX_OCA][7:6])
    begin
      next_cur.offLatch = 1'b1;
    end

    // Packet time limit
    if (pktStart)
    begin
      next_cur.pktCnt = 20'h00000;
      next_cur.pktRun = 1'b1;
      next_cur.pktAbort = 1'b0;
    end
    else if (pktDone)
    begin
      next_cur.pktRun = 1'b0;
    end
    else if (cur.pktRun)
    begin
      if (cur.pktCnt == 20'(PKT_CYC - 1))
      begin
        next_cur.pktRun = 1'b0;
        next_cur.pktAbort = 1'b1;
      end
      else
      begin
        next_cur.pktCnt = cur.pktCnt + 20'h00001;
      end
    end

    // Input thresholds with hysteresis
    if (vinFix >= prcL11(cur.regs[IX_VON]))
    begin
      next_cur.convOn = 1'b1;
    end
    else if (vinFix <= prcL11(cur.regs[IX_VOFF]))
    begin
      next_cur.convOn = 1'b0;
    end

    // Slew toward target on each tick
    next_cur.tickCnt = tick ? 16'h0000 : cur.tickCnt + 16'h0001;
    if (tick)
    begin
      if (cur.vout < target)
      begin
        next_cur.vout = (target - cur.vout > step) ?
                        cur.vout + step : target;
      end
      else if (cur.vout > target)
      begin
        next_cur.vout = (cur.vout - target > step) ?
                        cur.vout - step : target;
      end
    end

    case (cur.st)
      ST_IDLE:
      begin
        if (take && !cur.pktAbort)
        begin
          case (req.kind)
            KIND_READ:
            begin
              next_cur.rdValid = 1'b1;
              if (hit && req.word == REG_WORD[ix])
              begin
                // Low byte goes first
                next_cur.rdByte = cur.regs[ix][7:0];
                next_cur.hiByte = cur.regs[ix][15:8];
                next_cur.rdLast = !req.word;
                next_cur.st = req.word ? ST_READ_HI : ST_IDLE;
              end
              else
              begin
                next_cur.rdByte = NO_DATA;
                next_cur.rdLast = 1'b1;
                next_cur.faults.commsMemoryFault = 1'b1;
              end
            end
            KIND_WRITE:
            begin
              if (hit && !REG_RO[ix] && req.word == REG_WORD[ix] &&
                  !wpBlock)
              begin
                next_cur.regs[ix] = req.word ?
                  {req.dataHi, req.dataLo} : {8'h00, req.dataLo};
              end
              else
              begin
                // Also catches blind writes into reserved codes
                next_cur.faults.commsMemoryFault = 1'b1;
              end
            end
            KIND_SEND:
            begin
              if (req.code == CMD_STORE)
              begin
                next_cur.nvmCnt = 8'(NVM_BUSY_CYC - 1);
                next_cur.st = ST_STORE;
              end
              else if (req.code == CMD_RESTORE)
              begin
                next_cur.nvmCnt = 8'(NVM_BUSY_CYC - 1);
                next_cur.st = ST_RESTORE;
              end
              else if (req.code != CMD_CLEAR || reserved)
              begin
                next_cur.faults.commsMemoryFault = 1'b1;
              end
            end
            default:
            begin
              next_cur.faults.commsMemoryFault = 1'b1;
            end
          endcase
        end
      end
      ST_READ_HI:
      begin
        next_cur.rdValid = 1'b1;
        next_cur.rdLast = 1'b1;
        next_cur.rdByte = cur.hiByte;
        next_cur.st = ST_IDLE;
      end
      ST_STORE:
      begin
        // Registers cannot change while busy, copy at the end
        next_cur.nvmCnt = cur.nvmCnt - 8'h01;
        if (cur.nvmCnt == 8'h00)
        begin
          for (int i = 0; i < NREG; i++)
          begin
            if (REG_NV[i])
            begin
              next_cur.nvm[i] = cur.regs[i];
            end
          end
          next_cur.st = ST_IDLE;
        end
      end
      ST_RESTORE:
      begin
        next_cur.nvmCnt = cur.nvmCnt - 8'h01;
        if (cur.nvmCnt == 8'h00)
        begin
          for (int i = 0; i < NREG; i++)
          begin
            if (REG_NV[i])
            begin
              next_cur.regs[i] = cur.nvm[i];
            end
          end
          next_cur.st = ST_IDLE;
        end
      end
      default:
      begin
        next_cur.st = ST_IDLE;
      end
    endcase

    // A fault clear also releases the action latch, unless a fault event arrives in the same cycle
    if (take && !cur.pktAbort && req.kind == KIND_SEND &&
        req.code == CMD_CLEAR && !(ovDetect || uvDetect || ocDetect))
    begin
      next_cur.offLatch = 1'b0;
    end
  end

  // State register
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cur <= '0;
      cur.st <= ST_IDLE;
      cur.regs <= REG_RESET;
      cur.nvm <= REG_RESET;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  // Outputs
  assign rsp.ready = (cur.st == ST_IDLE);
  assign rsp.busy = (cur.st != ST_IDLE);
  assign rsp.rdValid = cur.rdValid;
  assign rsp.rdLast = cur.rdLast;
  assign rsp.rdByte = cur.rdByte;
  assign pktAbort = cur.pktAbort;
  assign faults = cur.faults;
  assign convActive = cur.convOn;
  assign railEnable = railOn;
  assign voutNow = cur.vout;
  assign regView = cur.regs;

endmodule

// File: verification/prc_host_model.sv
// Host model issuing register requests and framing packets
`timescale 1ns/1ps
module prc_host_model
  import prc_pkg::*;
(
  input wire logic core_clk,
  input wire prc_rsp_t rsp,
  output prc_req_t req,
  output logic pktStart,
  output logic pktDone
);
  logic hang;
  // Idle at time zero
  initial
  begin
    req = '0;
    pktStart = 1'b0;
    pktDone = 1'b0;
    hang = 1'b0;
  end
  // Packet ends with each accepted request unless stalled
  always @(posedge core_clk)
  begin
    pktDone <= req.valid && rsp.ready && !hang;
  end
  // Present a request, hold it until accepted
  task automatic xfer(input prc_kind_t k, input logic w,
    input logic [7:0] c, input logic [15:0] d);
    req <= '{1'b1, k, w, c, d[7:0], d[15:8]};
    do
      @(posedge core_clk);
    while (rsp.ready !== 1'b1);
  endtask
  // Release; stale fields inverted
  task automatic idle();
    req <= {1'b0, ~req[$bits(prc_req_t)-2:0]};
    @(posedge core_clk);
  endtask
  // Open a packet; a stalled one never completes
  task automatic open_pkt(input logic h);
    hang <= h;
    pktStart <= 1'b1;
    @(posedge core_clk);
    pktStart <= 1'b0;
  endtask
endmodule

// File: verification/prc_rail_cmd_bank_sva.sv
// Port assertions for the rail command register bank
`timescale 1ns/1ps
module prc_rail_cmd_bank_sva
  import prc_pkg::*;
#(
  parameter int PKT_CYC = 50,
  parameter int TICK_CYC = 8
)
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire prc_req_t req,
  input wire prc_rsp_t rsp,
  input wire logic pktStart,
  input wire logic pktAbort,
  input wire logic ovDetect,
  input wire logic uvDetect,
  input wire logic ocDetect,
  input wire prc_fault_t faults,
  input wire logic railEnable,
  input wire logic [15:0] voutNow,
  input wire logic [0:NREG-1][15:0] regView
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rstn);
  logic take;
  // Request accepted this cycle
  assign take = req.valid && rsp.ready && !pktAbort;
  // Store or reload: 64 busy cycles, then ready
  sequence nvm_busy_s;
    ##1 rsp.busy [*8] ##56 rsp.busy ##1 rsp.ready;
  endsequence
  // Word read: low byte, then high byte last
  sequence word_pair_s;
    ##1 rsp.rdValid && !rsp.rdLast && rsp.rdByte == regView[IX_VCMD][7:0]
    ##1 rsp.rdValid && rsp.rdLast && rsp.rdByte == regView[IX_VCMD][15:8];
  endsequence
  busy_refuse_a: assert property (
    rsp.busy && req.valid && !pktAbort |=> faults.busyFault)
    else $error("request during busy not flagged");
  nvm_busy_a: assert property (
    take && req.kind == KIND_SEND
    && (req.code == CMD_STORE || req.code == CMD_RESTORE) |-> nvm_busy_s)
    else $error("store or reload busy window wrong");
  word_read_a: assert property (
    take && req.kind == KIND_READ && req.word && req.code == 8'h21
    |-> word_pair_s)
    else $error("word read bytes wrong");
  bad_code_a: assert property (
    take && req.kind == KIND_READ
    && (req.code >= RESERVED_LO || req.code == 8'h05)
    |=> rsp.rdValid && rsp.rdLast && rsp.rdByte == 8'hFF
    && faults.commsMemoryFault)
    else $error("bad code read not refused");
  fault_clear_a: assert property (
    take && req.kind == KIND_SEND && req.code == CMD_CLEAR
    && !ovDetect && !uvDetect && !ocDetect |=> faults == '0)
    else $error("fault clear left a flag");
  ceiling_a: assert property (
    voutNow > $past(voutNow) && $stable(regView[IX_VMAX])
    |-> voutNow <= regView[IX_VMAX])
    else $error("set point above ceiling");
  abort_hold_a: assert property (
    pktAbort && !pktStart |=> pktAbort)
    else $error("packet abort dropped early");
  ov_action_a: assert property (
    ovDetect && regView[IX_OVA][7:6] != 2'h0 |=> faults.ov && !railEnable)
    else $error("overvoltage action not taken");
endmodule

bind prc_rail_cmd_bank prc_rail_cmd_bank_sva #(
  .PKT_CYC(PKT_CYC), .TICK_CYC(TICK_CYC)
) chk (
  .core_clk(core_clk), .rstn(rstn), .req(req), .rsp(rsp),
  .pktStart(pktStart), .pktAbort(pktAbort), .ovDetect(ovDetect),
  .uvDetect(uvDetect), .ocDetect(ocDetect), .faults(faults),
  .railEnable(railEnable), .voutNow(voutNow), .regView(regView)
);

// File: verification/testbench.sv
// Self-checking bench for the rail command register bank
`timescale 1ns/1ps
module testbench
  import prc_pkg::*;
;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic pktStart, pktDone, pktAbort, enablePin, convActive, railEnable;
  logic ovDetect, uvDetect, ocDetect;
  logic [15:0] vinMeas, voutNow, r;
  logic [0:NREG-1][15:0] regView;
  logic [31:0] seed = 32'h00000049;
  logic [15:0] expQ[$];
  prc_req_t req;
  prc_rsp_t rsp;
  prc_fault_t faults;
  int err_count = 0;
  int n_checks = 0;

  // 40 MHz clock
  always #12.5 core_clk = ~core_clk;

  // Host model and block
  prc_host_model host (.core_clk(core_clk), .rsp(rsp), .req(req),
    .pktStart(pktStart), .pktDone(pktDone));
  prc_rail_cmd_bank #(.PKT_CYC(50), .TICK_CYC(8)) uut (
    .core_clk(core_clk), .rstn(rstn), .req(req), .rsp(rsp),
    .pktStart(pktStart), .pktDone(pktDone), .pktAbort(pktAbort),
    .enablePin(enablePin), .vinMeas(vinMeas), .ovDetect(ovDetect),
    .uvDetect(uvDetect), .ocDetect(ocDetect), .faults(faults),
    .convActive(convActive), .railEnable(railEnable),
    .voutNow(voutNow), .regView(regView));

  // Value compare
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Flag compare
  task automatic flag(input logic f, input logic e);
    check({15'h0000, f}, {15'h0000, e});
  endtask
  function automatic logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction
  task automatic wait_n(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // Read, noting expected bytes low first
  task automatic rd(input logic [7:0] c, input logic w,
    input logic [15:0] e);
    expQ.push_back({8'h00, e[7:0]});
    if (w)
      expQ.push_back({8'h00, e[15:8]});
    host.xfer(KIND_READ, w, c, 16'h0000);
  endtask
  task automatic wr(input logic [7:0] c, input logic w,
    input logic [15:0] d);
    host.xfer(KIND_WRITE, w, c, d);
  endtask
  task automatic send(input logic [7:0] c);
    host.xfer(KIND_SEND, 1'b0, c, 16'h0000);
  endtask
  // One-cycle fault events {ov, uv, oc}
  task automatic hit(input logic [2:0] f);
    {ovDetect, uvDetect, ocDetect} <= f;
    wait_n(1);
    {ovDetect, uvDetect, ocDetect} <= 3'b000;
    wait_n(3);
  endtask
  task automatic endt(input string s);
    host.idle();
    wait_n(3);
    check(16'(expQ.size()), 16'h0000);
    $display("test %s done", s);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Read results against the oldest note
  always @(posedge core_clk)
  begin
    if (rsp.rdValid === 1'b1)
    begin
      if (expQ.size() == 0)
        check({8'h00, rsp.rdByte}, 16'h0100);
      else
        check({8'h00, rsp.rdByte}, expQ.pop_front());
    end
  end

  // Watchdog, over twenty times the expected run
  initial
  begin
    #500000;
    err_count++;
    test_done();
  end

  // Test sequence
  initial
  begin
    enablePin = 1'b1;
    vinMeas = 16'hCA00;
    {ovDetect, uvDetect, ocDetect} = 3'b000;
    wait_n(3);
    rstn <= 1'b1;
    host.open_pkt(1'b0);
    for (int i = 0; i < NREG; i++)
      rd(REG_CODE[i], REG_WORD[i], REG_RESET[i]);
    rd(8'h01, 1'b0, 16'h0080);
    rd(8'h02, 1'b0, 16'h001E);
    rd(8'h19, 1'b0, 16'h00B0);
    rd(8'h47, 1'b0, 16'h0000);
    endt("reset");
    rd(8'h05, 1'b0, 16'h00FF);
    rd(8'hD5, 1'b0, 16'h00FF);
    wr(8'h20, 1'b0, 16'h0055);
    rd(8'h20, 1'b0, 16'h0014);
    endt("codes");
    flag(faults.commsMemoryFault, 1'b1);
    send(CMD_CLEAR);
    endt("clear");
    check({11'h000, faults}, 16'h0000);
    repeat (4)
    begin
      r = rnd();
      wr(8'h33, 1'b1, r);
      rd(8'h33, 1'b1, r);
    end
    wr(8'h10, 1'b0, 16'h0080);
    wr(8'h02, 1'b0, 16'h0000);
    rd(8'h02, 1'b0, 16'h001E);
    wr(8'h10, 1'b0, 16'h0000);
    rd(8'h10, 1'b0, 16'h0000);
    endt("guard");
    wr(8'h21, 1'b1, 16'h0F80);
    send(CMD_STORE);
    wr(8'h21, 1'b1, 16'h0F90);
    rd(8'h21, 1'b1, 16'h0F90);
    send(CMD_RESTORE);
    rd(8'h21, 1'b1, 16'h0F80);
    endt("store");
    flag(faults.busyFault, 1'b1);
    send(CMD_CLEAR);
    wr(8'h24, 1'b1, 16'h0800);
    wr(8'h01, 1'b0, 16'h00A0);
    host.idle();
    vinMeas <= 16'hD300;
    wait_n(300);
    flag(convActive, 1'b1);
    flag(railEnable, 1'b1);
    check(voutNow, 16'h0800);
    wr(8'h24, 1'b1, 16'h5800);
    host.idle();
    wait_n(4);
    flag(voutNow <= 16'h0C00, 1'b1);
    wait_n(100);
    check(voutNow, 16'h10CD);
    wr(8'h01, 1'b0, 16'h0090);
    host.idle();
    wait_n(20);
    check(voutNow, 16'h0F33);
    $display("test margin done");
    vinMeas <= 16'hCB20;
    wait_n(5);
    flag(convActive, 1'b1);
    vinMeas <= 16'hCA00;
    wait_n(5);
    flag(convActive, 1'b0);
    vinMeas <= 16'hCB20;
    wait_n(5);
    flag(convActive, 1'b0);
    vinMeas <= 16'hD300;
    wait_n(5);
    $display("test threshold done");
    hit(3'b100);
    flag(faults.ov, 1'b1);
    flag(railEnable, 1'b0);
    send(CMD_CLEAR);
    endt("overvoltage");
    flag(railEnable, 1'b1);
    hit(3'b001);
    flag(faults.oc, 1'b1);
    flag(railEnable, 1'b1);
    hit(3'b010);
    flag(faults.uv, 1'b1);
    flag(railEnable, 1'b0);
    send(CMD_CLEAR);
    endt("faults");
    enablePin <= 1'b0;
    wait_n(4);
    flag(railEnable, 1'b0);
    enablePin <= 1'b1;
    wait_n(4);
    flag(railEnable, 1'b1);
    $display("test pin done");
    host.open_pkt(1'b1);
    wait_n(60);
    flag(pktAbort, 1'b1);
    host.xfer(KIND_READ, 1'b0, 8'h01, 16'h0000);
    endt("abort");
    host.open_pkt(1'b0);
    wait_n(2);
    flag(pktAbort, 1'b0);
    test_done();
  end
endmodule
